/* ppa_map.svh */
`ifndef PPA_MAP_SVH
`define PPA_MAP_SVH

// Sample and clock timing
`define PPA_CLK_PERIOD_NS   5
`define PPA_SAMPLE_RATE_HZ  833000
`define PPA_SAMPLE_BITS     16
`define PPA_CLK_MHZ         200
`define PPA_MASTER_MHZ      10
`define PPA_BANDWIDTH_HZ    14000

// Current channel dc removal, corner near 260 Hz at the sample rate (the dc estimate drops only PPA_HPF_SHIFT-1 bits)
`define PPA_HPF_SHIFT       10

// Single-pole power low-pass, -3 dB corner in Hz
`define PPA_LPF_CUTOFF_HZ   8
// 2*pi*8/833000 is about 2**-14
`define PPA_LPF_SHIFT       14

// Pulse high time and its cycle count (least time, rounded up)
`define PPA_PULSE_NS        100
`define PPA_PULSE_CYC       ((`PPA_PULSE_NS + `PPA_CLK_PERIOD_NS - 1) / `PPA_CLK_PERIOD_NS)

// Energy quantum per low-rate pulse, one per rate select code
`define PPA_THR_0           48'h0080_0000_0000
`define PPA_THR_1           48'h0100_0000_0000
`define PPA_THR_2           48'h0200_0000_0000
`define PPA_THR_3           48'h0400_0000_0000

// Calibration quantum is the low-rate quantum shifted down
`define PPA_CAL_SHIFT       7

// Pipeline and accumulator widths
`define PPA_PROD_W          32
`define PPA_LP_W            40
`define PPA_ACC_W           48
`define PPA_CNT_W           8

`endif

/* ppa_pkg.sv */
`include "ppa_map.svh"

package ppa_pkg;

  // Six modulator outputs taken together
  typedef struct packed {
    logic [2:0][`PPA_SAMPLE_BITS-1:0] cur;
    logic [2:0][`PPA_SAMPLE_BITS-1:0] volt;
  } ppa_sample_t;

  // Which low-rate output the next quantum goes to
  typedef enum logic [0:0] {
    PPA_SEL_A = 1'b0,
    PPA_SEL_B = 1'b1
  } ppa_lr_sel_t;

  // Pulse request from the two accumulators
  typedef struct packed {
    logic slow;
    logic cal;
  } ppa_fire_t;

endpackage : ppa_pkg

/* ppa_top.sv */
`timescale 1ns/100ps
`include "ppa_map.svh"
// Contract
// - Six 16-bit sigma-delta sample streams enter the datapath at the 833 kHz rate.
// - Each current channel is high-pass filtered to strip its dc offset before multiplying.
// - Each phase multiplies its filtered current directly by its voltage.
// - Each phase product is low-pass filtered on its own, keeping its dc term as real power.
// - Total real power is the sum of the three phase real powers.
// - Low-rate pulses come from accumulating total power over a long interval.
// - The calibration pulse uses a much shorter interval and so a higher pulse rate.
// - With the nominal master clock the chain passes input content up to 14 kHz.
// - The sum is the same whichever two of the three phases carry the signal.
// - Sum mode high adds signed phase energies, low adds their absolute values.
// - Two rate select inputs choose one of four scaling quanta for pulse conversion.
// - The phase low-pass is single-pole with its -3 dB corner at 8 Hz.
// - Each low-rate energy quantum appears as an active-high pulse.
module ppa_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Modulator sample stream
  input  wire logic                  smp_valid,
  input  wire ppa_pkg::ppa_sample_t  smp,
  // Mode straps
  input  wire logic                  sum_mode_select,
  input  wire logic                  rate_select_lo,
  input  wire logic                  rate_select_hi,
  // Pulse outputs
  output logic                       calibration_pulse_out,
  output logic                       low_rate_pulse_out_a,
  output logic                       low_rate_pulse_out_b
);
  import ppa_pkg::*;

  localparam int PW = `PPA_PROD_W;
  localparam int LW = `PPA_LP_W;
  localparam int AW = `PPA_ACC_W;
  localparam int CW = `PPA_CNT_W;
  localparam int HS = `PPA_HPF_SHIFT;

  // Stage valids: product, sum, accumulate
  logic [2:0] vld_d, vld_q;

  logic signed [2:0][LW-1:0] lp_q;

  // Per-phase filter and multiplier chain
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      logic signed [`PPA_SAMPLE_BITS+HS-1:0] dc_d, dc_q;
      logic signed [`PPA_SAMPLE_BITS:0]      hp_d, hp_q;
      logic signed [`PPA_SAMPLE_BITS-1:0]    v_d, v_q;
      logic signed [PW:0]                    prod;
      logic signed [LW-1:0]                  lp_d, lp_r;
      logic signed [LW-1:0]                  err;

      always_comb begin
        dc_d = dc_q;
        hp_d = hp_q;
        v_d  = v_q;
        prod = '0;
        err  = '0;
        lp_d = lp_r;
        if (smp_valid) begin
          hp_d = $signed({smp.cur[ph][`PPA_SAMPLE_BITS-1], smp.cur[ph]})
               - $signed(dc_q[`PPA_SAMPLE_BITS+HS-1 -: `PPA_SAMPLE_BITS+1]);
          // Sign-extend the residue to the integrator width
          dc_d = dc_q + (`PPA_SAMPLE_BITS+HS)'(hp_d);
          v_d  = $signed(smp.volt[ph]);
        end
        if (vld_q[0]) begin
          prod = (PW+1)'(hp_q * v_q);
          err  = LW'(prod) - lp_r;
          lp_d = lp_r + (err >>> `PPA_LPF_SHIFT);
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          dc_q <= '0;
          hp_q <= '0;
          v_q  <= '0;
          lp_r <= '0;
        end else begin
          dc_q <= dc_d;
          hp_q <= hp_d;
          v_q  <= v_d;
          lp_r <= lp_d;
        end
      end

      assign lp_q[ph] = lp_r;
    end
  endgenerate

  // Phase sum and rate decode
  logic signed [AW-1:0] sum_d, sum_q;
  logic [AW-1:0]        thr_d, thr_q;
  logic signed [AW-1:0] term;

  always_comb begin
    vld_d = {vld_q[1:0], smp_valid};
    sum_d = sum_q;
    term  = '0;
    if (vld_q[1]) begin
      sum_d = '0;
      for (int k = 0; k < 3; k++) begin
        // Element select of a packed array is unsigned; keep the sign
        term = AW'($signed(lp_q[k]));
        if (!sum_mode_select && term < 0) begin
          term = -term;
        end
        sum_d = sum_d + term;
      end
    end
    unique case ({rate_select_hi, rate_select_lo})
      2'h0: thr_d = `PPA_THR_0;
      2'h1: thr_d = `PPA_THR_1;
      2'h2: thr_d = `PPA_THR_2;
      2'h3: thr_d = `PPA_THR_3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vld_q <= '0;
      sum_q <= '0;
      thr_q <= `PPA_THR_0;
    end else begin
      vld_q <= vld_d;
      sum_q <= sum_d;
      thr_q <= thr_d;
    end
  end

  // Two accumulators: index 0 low rate, index 1 calibration
  logic [1:0] fire;
  genvar ai;
  generate
    for (ai = 0; ai < 2; ai++) begin : g_acc
      logic signed [AW-1:0] acc_d, acc_q;
      logic signed [AW-1:0] lim;
      logic signed [AW-1:0] nxt;
      logic                 f_d, f_q;

      always_comb begin
        lim   = (ai == 0) ? $signed(thr_q) : $signed(thr_q >> `PPA_CAL_SHIFT);
        nxt   = acc_q + sum_q;
        acc_d = acc_q;
        f_d   = 1'b0;
        if (vld_q[2]) begin
          if (nxt >= lim) begin
            acc_d = nxt - lim;
            f_d   = 1'b1;
          end else if (nxt <= -lim) begin
            // Negative power floors at -lim so reversal banks at most one quantum of debt
            acc_d = -lim;
          end else begin
            acc_d = nxt;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          acc_q <= '0;
          f_q   <= 1'b0;
        end else begin
          acc_q <= acc_d;
          f_q   <= f_d;
        end
      end

      assign fire[ai] = f_q;
    end
  endgenerate

  // Pulse stretchers and low-rate alternation
  ppa_fire_t         req;
  ppa_lr_sel_t       sel_d, sel_q;
  logic [2:0][CW-1:0] cnt_d, cnt_q;
  logic [2:0]        out_d, out_q;

  assign req.slow = fire[0];
  assign req.cal  = fire[1];

  always_comb begin
    sel_d = sel_q;
    cnt_d = cnt_q;
    for (int k = 0; k < 3; k++) begin
      if (cnt_q[k] != '0) begin
        cnt_d[k] = cnt_q[k] - CW'(1);
      end
    end
    // A new quantum during a pulse on the same output restarts it rather than queueing
    if (req.cal) begin
      cnt_d[2] = CW'(`PPA_PULSE_CYC);
    end
    if (req.slow) begin
      unique case (sel_q)
        PPA_SEL_A: cnt_d[0] = CW'(`PPA_PULSE_CYC);
        PPA_SEL_B: cnt_d[1] = CW'(`PPA_PULSE_CYC);
      endcase
      sel_d = (sel_q == PPA_SEL_A) ? PPA_SEL_B : PPA_SEL_A;
    end
    for (int k = 0; k < 3; k++) begin
      out_d[k] = (cnt_d[k] != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= PPA_SEL_A;
      cnt_q <= '0;
      out_q <= '0;
    end else begin
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  // Outputs straight from flops
  assign low_rate_pulse_out_a  = out_q[0];
  assign low_rate_pulse_out_b  = out_q[1];
  assign calibration_pulse_out = out_q[2];

endmodule : ppa_top

/* ppa_src_model.sv */
`timescale 1ns/100ps
module ppa_src_model (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Scenario controls
  input  wire logic            run,
  input  wire logic            dc,
  input  wire logic [2:0]      ph_on,
  input  wire logic [2:0]      ph_neg,
  // Sample stream
  output logic                 smp_valid,
  output ppa_pkg::ppa_sample_t smp
);
  import ppa_pkg::*;
  logic [2:0]  gap_q;
  logic        sgn_q;
  logic        take;
  ppa_sample_t fresh;
  // Sample due this cycle
  assign take = run && gap_q == 3'h4;
  always_comb begin
    fresh = '0;
    for (int i = 0; i < 3; i++) begin
      fresh.cur[i]  = ph_on[i] ? (sgn_q ? 16'h8001 : 16'h7FFF) : 16'h0000;
      fresh.volt[i] = ph_on[i] ? (sgn_q ^ ph_neg[i] ? 16'h8001 : 16'h7FFF) : 16'h0000;
    end
  end
  // One pair every fifth cycle; data toggles between so a stray grab shows
  // paced 16-bit samples
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q     <= 3'h0;
      sgn_q     <= 1'b0;
      smp_valid <= 1'b0;
      smp       <= '0;
    end else begin
      gap_q     <= (gap_q == 3'h4) ? 3'h0 : gap_q + 3'h1;
      smp_valid <= take;
      smp       <= take ? fresh : ~smp;
      if (take) begin
        sgn_q <= ~sgn_q & ~dc;
      end
    end
  end
endmodule : ppa_src_model

/* ppa_top_assertions.sv */
`timescale 1ns/100ps
`include "ppa_map.svh"
module ppa_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic smp_valid,
  input wire logic calibration_pulse_out,
  input wire logic low_rate_pulse_out_a,
  input wire logic low_rate_pulse_out_b
);
  logic       cal;
  logic       a;
  logic       b;
  logic [7:0] cal_run_q;
  logic [7:0] a_run_q;
  logic       b_q;
  logic       last_b_q;
  logic       cal_seen_q;
  assign cal = calibration_pulse_out;
  assign a   = low_rate_pulse_out_a;
  assign b   = low_rate_pulse_out_b;
  // Run lengths saturate so a merged pulse never wraps
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_run_q  <= 8'h00;
      a_run_q    <= 8'h00;
      b_q        <= 1'b0;
      last_b_q   <= 1'b1;
      cal_seen_q <= 1'b0;
    end else begin
      cal_run_q  <= cal ? cal_run_q + {7'h00, ~&cal_run_q} : 8'h00;
      a_run_q    <= a ? a_run_q + {7'h00, ~&a_run_q} : 8'h00;
      b_q        <= b;
      last_b_q   <= (a && a_run_q == 8'h00) ? 1'b0 : (b && !b_q) ? 1'b1 : last_b_q;
      cal_seen_q <= ((a && a_run_q == 8'h00) || (b && !b_q)) ? cal : cal_seen_q | cal;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_release_quiet: assert property ($fell(rst) |-> !(cal || a || b) [*4])
    else $error("pulse right after reset");
  chk_cal_cause: assert property ($rose(cal) |-> $past(smp_valid, 5))
    else $error("cal pulse without sample");
  chk_lr_cause: assert property ($rose(a || b) |-> $past(smp_valid, 5))
    else $error("low-rate pulse without sample");
  chk_cal_width: assert property ($fell(cal) |-> cal_run_q >= `PPA_PULSE_CYC)
    else $error("cal pulse too short");
  chk_lra_width: assert property ($fell(a) |-> a_run_q >= `PPA_PULSE_CYC)
    else $error("low-rate pulse too short");
  chk_lr_alternate: assert property ($rose(a) || $rose(b) |-> $rose(a) == last_b_q)
    else $error("low-rate outputs out of turn");
  chk_lr_exclusive: assert property (!(a && b))
    else $error("both low-rate outputs high");
  chk_cal_first: assert property ($rose(a || b) |-> cal_seen_q)
    else $error("low-rate pulse before any cal");
  cov_cal: cover property ($rose(cal));
  cov_lra: cover property ($rose(a));
  cov_cal_end: cover property ($fell(cal));
endmodule : ppa_top_checker

bind ppa_top ppa_top_checker u_chk (.clk(clk), .rst(rst), .smp_valid(smp_valid),
  .calibration_pulse_out(calibration_pulse_out),
  .low_rate_pulse_out_a(low_rate_pulse_out_a), .low_rate_pulse_out_b(low_rate_pulse_out_b));

/* ppa_top_tb.sv */
`timescale 1ns/100ps
module ppa_top_tb;
  import ppa_pkg::*;
  logic        clk;
  logic        rst;
  logic        run;
  logic        dc;
  logic [2:0]  ph_on;
  logic [2:0]  ph_neg;
  logic        smp_valid;
  ppa_sample_t smp;
  logic        mode;
  logic [1:0]  rate;
  logic        cal;
  logic        lr_a;
  logic        lr_b;
  logic [2:0]  prev;
  int          n_cal;
  int          n_a;
  int          n_b;
  int          fail_count;
  int          samples_checked;

  ppa_src_model src (.clk(clk), .rst(rst), .run(run), .dc(dc), .ph_on(ph_on),
    .ph_neg(ph_neg), .smp_valid(smp_valid), .smp(smp));
  ppa_top dut (.clk(clk), .rst(rst), .smp_valid(smp_valid), .smp(smp),
    .sum_mode_select(mode), .rate_select_lo(rate[0]), .rate_select_hi(rate[1]),
    .calibration_pulse_out(cal), .low_rate_pulse_out_a(lr_a), .low_rate_pulse_out_b(lr_b));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Count rising edges of each output; cleared while reset is held
  always @(posedge clk) begin
    prev <= {cal, lr_a, lr_b};
    if (rst) begin
      n_cal = 0;
      n_a = 0;
      n_b = 0;
    end else begin
      // Unknown counts as high so it cannot pass a zero-count check
      if (cal !== 1'b0 && prev[2] !== 1'b1) n_cal++;
      if (lr_a !== 1'b0 && prev[1] !== 1'b1) n_a++;
      if (lr_b !== 1'b0 && prev[0] !== 1'b1) n_b++;
    end
  end

  task automatic check(string what, int exp, int got);
    samples_checked++;
    if (exp != got) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  // Fresh reset, then a fixed window of samples; filters start cold each time
  task automatic run_case(logic [2:0] on, logic [2:0] neg, logic d, logic m,
                          logic [1:0] r, int nsmp);
    rst    <= 1'b1;
    ph_on  <= on;
    ph_neg <= neg;
    dc     <= d;
    mode   <= m;
    rate   <= r;
    @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    repeat (nsmp * 5) @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : run_case

  task automatic t_reset();
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("idle outputs", 1, int'({cal, lr_a, lr_b} === 3'b000));
    $display("test reset done");
  endtask : t_reset

  task automatic t_rates();
    for (int r = 3; r >= 0; r--) begin
      run_case(3'b111, 3'b000, 1'b0, 1'b1, r[1:0], 2800);
      check("low-rate fired", int'(r == 0), int'(n_a + n_b > 0));
      check("cal fired", 1, int'(n_cal > 0));
    end
    check("a leads b", 1, n_a - n_b);
    check("cal outpaces", 1, int'(n_cal > n_a + n_b));
    $display("test rates done");
  endtask : t_rates

  task automatic t_dc();
    run_case(3'b001, 3'b000, 1'b1, 1'b1, 2'h3, 2000);
    check("dc low-rate", 0, n_a + n_b);
    $display("test dc done");
  endtask : t_dc

  task automatic t_sum_mode();
    run_case(3'b111, 3'b111, 1'b0, 1'b1, 2'h0, 600);
    check("signed negative", 0, n_cal);
    run_case(3'b111, 3'b111, 1'b0, 1'b0, 2'h0, 600);
    check("absolute negative", 1, int'(n_cal > 0));
    $display("test sum mode done");
  endtask : t_sum_mode

  task automatic t_two_phase();
    int first;
    run_case(3'b011, 3'b000, 1'b0, 1'b1, 2'h0, 600);
    first = n_cal;
    run_case(3'b110, 3'b000, 1'b0, 1'b1, 2'h0, 600);
    check("two-phase any", 1, int'(first > 0));
    check("two-phase match", first, n_cal);
    $display("test two phase done");
  endtask : t_two_phase

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    rst = 1'b1;
    run = 1'b0;
    dc = 1'b0;
    ph_on = 3'h0;
    ph_neg = 3'h0;
    mode = 1'b1;
    rate = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    t_reset();
    t_rates();
    t_dc();
    t_sum_mode();
    t_two_phase();
    print_verdict();
  end
endmodule : ppa_top_tb
